// ---- tmpc_host_clock.sv ----
// Package of constants for the transceiver mode pin control, and its host clock generator.
package tmpc_pkg;

	localparam int unsigned TMPC_CLK_HZ = 200000000;
	localparam int unsigned TMPC_OFF_TO_IDLE_MS = 25;
	localparam int unsigned TMPC_HIB_TO_IDLE_MS = 20;
	localparam int unsigned TMPC_DOZE_TO_IDLE_US = 300;
	localparam int unsigned TMPC_IDLE_TO_RADIO_US = 144;
	localparam int unsigned TMPC_OFF_TO_IDLE_CYC = TMPC_OFF_TO_IDLE_MS * (TMPC_CLK_HZ / 1000);
	localparam int unsigned TMPC_HIB_TO_IDLE_CYC = TMPC_HIB_TO_IDLE_MS * (TMPC_CLK_HZ / 1000);
	localparam int unsigned TMPC_DOZE_TO_IDLE_CYC = TMPC_DOZE_TO_IDLE_US * (TMPC_CLK_HZ / 1000000);
	localparam int unsigned TMPC_IDLE_TO_RADIO_CYC =
		TMPC_IDLE_TO_RADIO_US * (TMPC_CLK_HZ / 1000000);

	localparam int unsigned TMPC_CNT_W = 32;
	localparam int unsigned TMPC_ACC_W = 32;
	localparam int unsigned TMPC_SEL_W = 3;

	// Host clock base is the 16 MHz crystal rate; every choice divides it.
	localparam longint unsigned TMPC_XTAL_HZ = 64'd16000000;
	localparam longint unsigned TMPC_ACC_SCALE =
		((64'h1 << TMPC_ACC_W) * TMPC_XTAL_HZ) / 64'(TMPC_CLK_HZ);

	localparam logic [TMPC_SEL_W-1:0] TMPC_SEL_RESET = 3'h6;
	localparam logic [TMPC_SEL_W-1:0] TMPC_SEL_SLOW_MIN = 3'h4;

	typedef enum logic [7:0] {
		TMPC_OFF = 8'h01,
		TMPC_IDLE = 8'h02,
		TMPC_HIBERNATE = 8'h04,
		TMPC_DOZE = 8'h08,
		TMPC_WAKING = 8'h10,
		TMPC_WARMUP = 8'h20,
		TMPC_RECEIVE = 8'h40,
		TMPC_TRANSMIT = 8'h80
	} tmpc_mode_e;

	// Divisors of 16 MHz: 16, 8, 4, 2, 1 MHz, 62.5 kHz, about 32.786 kHz, about 16.393 kHz.
	function automatic logic [TMPC_ACC_W-1:0] tmpc_increment(input logic [TMPC_SEL_W-1:0] sel);
		longint unsigned div;
		div = 64'd1;
		case (sel)
			3'h0: div = 64'd1;
			3'h1: div = 64'd2;
			3'h2: div = 64'd4;
			3'h3: div = 64'd8;
			3'h4: div = 64'd16;
			3'h5: div = 64'd256;
			3'h6: div = 64'd488;
			default: div = 64'd976;
		endcase
		return TMPC_ACC_W'(TMPC_ACC_SCALE / div);
	endfunction

endpackage

`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// A phase accumulator stands in for a divider, since 16 MHz is no whole fraction of the core
// clock; the cost is up to one core period of edge jitter.
module tmpc_host_clock (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic run_in,
	input wire logic [tmpc_pkg::TMPC_SEL_W-1:0] select_in,
	output logic clock_level_out
);
	import tmpc_pkg::*;

	logic [TMPC_ACC_W-1:0] acc_q;
	logic [TMPC_ACC_W-1:0] acc_d;

	always_comb begin
		acc_d = '0;
		if (run_in) begin
			acc_d = acc_q + tmpc_increment(select_in);
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			acc_q <= '0;
		end else begin
			acc_q <= acc_d;
		end
	end

	assign clock_level_out = acc_q[TMPC_ACC_W-1];

endmodule

`default_nettype wire

// ---- tmpc_mode_ctrl.sv ----
// Operating mode control of the transceiver pins: reset, sequence trigger, wake and host clock.
//
// Summary of operation
// - Reset low holds Off and clears state.
// - Reset release leads to Idle with defaults.
// - Trigger rising edge starts programmed receive or transmit.
// - Trigger low forces Idle, ends radio activity.
// - Wake low brings Hibernate or Doze to Idle.
// - Host clock offers eight rates, default 32.786 kHz.
// - Indicator select drives CRC valid on pin 2.
// - Indicator select drives out-of-Idle on pin 1.
// - Off tristates outputs; Off to Idle 25 ms.
// - Hibernate stops clock, keeps data; 20 ms back.
// - Doze leaves on wake or timer match.
// - Idle to receive or transmit takes 144 us.
`timescale 1ns/1ps
`default_nettype none

module tmpc_mode_ctrl #(
	parameter int unsigned OFF_TO_IDLE_CYC = tmpc_pkg::TMPC_OFF_TO_IDLE_CYC,
	parameter int unsigned HIB_TO_IDLE_CYC = tmpc_pkg::TMPC_HIB_TO_IDLE_CYC,
	parameter int unsigned DOZE_TO_IDLE_CYC = tmpc_pkg::TMPC_DOZE_TO_IDLE_CYC,
	parameter int unsigned IDLE_TO_RADIO_CYC = tmpc_pkg::TMPC_IDLE_TO_RADIO_CYC
) (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic radio_sequence_trigger_in,
	input wire logic wake_request_n_in,
	input wire logic sequence_is_transmit_in,
	input wire logic hibernate_request_in,
	input wire logic doze_request_in,
	input wire logic doze_timer_match_in,
	input wire logic doze_clock_enable_in,
	input wire logic [tmpc_pkg::TMPC_SEL_W-1:0] host_clock_select_in,
	input wire logic indicator_select_in,
	input wire logic crc_valid_in,
	output tmpc_pkg::tmpc_mode_e mode_out,
	output logic state_lost_out,
	output logic receive_on_out,
	output logic transmit_on_out,
	output logic host_clock_out,
	output logic host_clock_oe_n_out,
	output logic out_of_idle_pin_out,
	output logic out_of_idle_pin_oe_n_out,
	output logic crc_ok_pin_out,
	output logic crc_ok_pin_oe_n_out
);
	import tmpc_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; stage 1 feeds only stage 2, stage 3 is kept for edge detection.
	logic [2:0] trig_sync_q;
	logic [2:0] trig_sync_d;
	logic [1:0] wake_sync_q;
	logic [1:0] wake_sync_d;
	logic trig_level;
	logic trig_rise;
	logic wake_active;

	always_comb begin
		trig_sync_d = {trig_sync_q[1:0], radio_sequence_trigger_in};
		wake_sync_d = {wake_sync_q[0], wake_request_n_in};
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			trig_sync_q <= 3'h0;
			wake_sync_q <= 2'h3;
		end else begin
			trig_sync_q <= trig_sync_d;
			wake_sync_q <= wake_sync_d;
		end
	end

	assign trig_level = trig_sync_q[1];
	assign trig_rise = trig_sync_q[1] & ~trig_sync_q[2];
	assign wake_active = ~wake_sync_q[1];

	////////////////////////////////////////////////////////////////////////////////
	// Mode sequencer with one shared delay counter.
	tmpc_mode_e mode_q;
	tmpc_mode_e mode_d;
	logic [TMPC_CNT_W-1:0] count_q;
	logic [TMPC_CNT_W-1:0] count_d;
	logic tx_q;
	logic tx_d;
	logic [TMPC_SEL_W-1:0] sel_q;
	logic [TMPC_SEL_W-1:0] sel_d;

	// Both sleep exits end on this count, so the shorter exit starts further up.
	localparam int unsigned WAKE_LAST =
		(HIB_TO_IDLE_CYC > DOZE_TO_IDLE_CYC ? HIB_TO_IDLE_CYC : DOZE_TO_IDLE_CYC) - 1;

	always_comb begin
		mode_d = mode_q;
		count_d = count_q;
		tx_d = tx_q;
		sel_d = sel_q;
		case (mode_q)
			TMPC_OFF: begin
				if (count_q >= TMPC_CNT_W'(OFF_TO_IDLE_CYC - 1)) begin
					mode_d = TMPC_IDLE;
					count_d = '0;
				end else begin
					count_d = count_q + 1'b1;
				end
			end
			TMPC_IDLE: begin
				// Settings are captured only in Idle, where the serial port is live.
				sel_d = host_clock_select_in;
				if (trig_rise) begin
					tx_d = sequence_is_transmit_in;
					mode_d = TMPC_WARMUP;
					count_d = '0;
				end else if (hibernate_request_in) begin
					mode_d = TMPC_HIBERNATE;
				end else if (doze_request_in) begin
					mode_d = TMPC_DOZE;
				end
			end
			TMPC_HIBERNATE: begin
				if (wake_active) begin
					mode_d = TMPC_WAKING;
					count_d = TMPC_CNT_W'(WAKE_LAST + 1 - HIB_TO_IDLE_CYC);
				end
			end
			TMPC_DOZE: begin
				if (wake_active || doze_timer_match_in) begin
					mode_d = TMPC_WAKING;
					count_d = TMPC_CNT_W'(WAKE_LAST + 1 - DOZE_TO_IDLE_CYC);
				end
			end
			TMPC_WAKING: begin
				// Each exit preloaded the counter, so one end count serves both.
				if (count_q >= TMPC_CNT_W'(WAKE_LAST)) begin
					mode_d = TMPC_IDLE;
					count_d = '0;
				end else begin
					count_d = count_q + 1'b1;
				end
			end
			TMPC_WARMUP: begin
				if (!trig_level) begin
					mode_d = TMPC_IDLE;
				end else if (count_q >= TMPC_CNT_W'(IDLE_TO_RADIO_CYC - 1)) begin
					mode_d = tx_q ? TMPC_TRANSMIT : TMPC_RECEIVE;
					count_d = '0;
				end else begin
					count_d = count_q + 1'b1;
				end
			end
			TMPC_RECEIVE, TMPC_TRANSMIT: begin
				if (!trig_level) begin
					mode_d = TMPC_IDLE;
				end
			end
			default: begin
				mode_d = TMPC_IDLE;
				count_d = '0;
			end
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			mode_q <= TMPC_OFF;
			count_q <= '0;
			tx_q <= 1'b0;
			sel_q <= TMPC_SEL_RESET;
		end else begin
			mode_q <= mode_d;
			count_q <= count_d;
			tx_q <= tx_d;
			sel_q <= sel_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Host clock and pin drivers.
	logic clk_run;
	logic clk_level;
	logic [6:0] pins_q;
	logic [6:0] pins_d;
	logic powered;

	assign clk_run = (mode_q == TMPC_IDLE) || (mode_q == TMPC_WARMUP) ||
		(mode_q == TMPC_RECEIVE) || (mode_q == TMPC_TRANSMIT) || (mode_q == TMPC_WAKING) ||
		(mode_q == TMPC_DOZE && doze_clock_enable_in && sel_q >= TMPC_SEL_SLOW_MIN);

	tmpc_host_clock u_host_clock (
		.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.run_in(clk_run),
		.select_in(sel_q),
		.clock_level_out(clk_level)
	);

	assign powered = (mode_q != TMPC_OFF);

	always_comb begin
		pins_d[0] = clk_level;
		pins_d[1] = ~powered;
		pins_d[2] = (mode_q != TMPC_IDLE) && powered;
		pins_d[3] = ~(powered && indicator_select_in);
		pins_d[4] = crc_valid_in && (mode_q != TMPC_OFF);
		pins_d[5] = ~(powered && indicator_select_in);
		pins_d[6] = ~powered;
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			pins_q <= 7'h6a;
		end else begin
			pins_q <= pins_d;
		end
	end

	assign mode_out = mode_q;
	assign host_clock_out = pins_q[0];
	assign host_clock_oe_n_out = pins_q[1];
	assign out_of_idle_pin_out = pins_q[2];
	assign out_of_idle_pin_oe_n_out = pins_q[3];
	assign crc_ok_pin_out = pins_q[4];
	assign crc_ok_pin_oe_n_out = pins_q[5];
	assign state_lost_out = pins_q[6];
	assign receive_on_out = (mode_q == TMPC_RECEIVE);
	assign transmit_on_out = (mode_q == TMPC_TRANSMIT);

endmodule

`default_nettype wire

// ---- tmpc_mode_ctrl_sva.sv ----
// Port assertions for the transceiver mode pin control.
`timescale 1ns/1ps
`default_nettype none
module tmpc_mode_ctrl_sva #(
	parameter int unsigned OFF_TO_IDLE_CYC = 20,
	parameter int unsigned HIB_TO_IDLE_CYC = 16,
	parameter int unsigned IDLE_TO_RADIO_CYC = 10
) (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic radio_sequence_trigger_in,
	input wire logic wake_request_n_in,
	input wire logic indicator_select_in,
	input wire logic crc_valid_in,
	input wire tmpc_pkg::tmpc_mode_e mode_out,
	input wire logic state_lost_out,
	input wire logic receive_on_out,
	input wire logic transmit_on_out,
	input wire logic out_of_idle_pin_out,
	input wire logic out_of_idle_pin_oe_n_out,
	input wire logic crc_ok_pin_out
);
	import tmpc_pkg::*;
	localparam int OFF_LO = OFF_TO_IDLE_CYC - 1;
	localparam int OFF_HI = OFF_TO_IDLE_CYC + 3;
	localparam int RAD_LO = IDLE_TO_RADIO_CYC - 1;
	localparam int RAD_HI = IDLE_TO_RADIO_CYC + 1;
	localparam int HIB_LO = HIB_TO_IDLE_CYC - 4;
	localparam int HIB_HI = HIB_TO_IDLE_CYC + 4;
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	////////////////////////////////////////////////////////////////////////////////
	// The pins pass two synchroniser flops, so every pin edge is seen three clocks late.
	sequence trig_rise_s;
		mode_out == TMPC_IDLE && $rose(radio_sequence_trigger_in) ##1 radio_sequence_trigger_in [*2];
	endsequence
	sequence wake_low_s;
		(mode_out == TMPC_HIBERNATE || mode_out == TMPC_DOZE) && !wake_request_n_in
			##1 !wake_request_n_in [*2];
	endsequence
	off_hold_a: assert property (disable iff (1'b0) !rst_n_in |=>
		mode_out == TMPC_OFF && state_lost_out) else $error("reset did not hold off");
	off_exit_a: assert property ($rose(rst_n_in) |->
		##[OFF_LO:OFF_HI] $rose(mode_out == TMPC_IDLE)) else $error("off exit time");
	seq_start_a: assert property (trig_rise_s |->
		##[0:2] mode_out == TMPC_WARMUP) else $error("trigger edge not taken");
	warm_time_a: assert property (disable iff (!rst_n_in || !radio_sequence_trigger_in)
		$rose(mode_out == TMPC_WARMUP) |-> ##[RAD_LO:RAD_HI] $rose(receive_on_out || transmit_on_out))
		else $error("warmup time");
	trig_idle_a: assert property ($fell(radio_sequence_trigger_in) &&
		(mode_out == TMPC_WARMUP || receive_on_out || transmit_on_out) |-> ##[2:4] mode_out == TMPC_IDLE)
		else $error("trigger low did not force idle");
	wake_exit_a: assert property (wake_low_s |-> ##[0:2] mode_out == TMPC_WAKING)
		else $error("wake not taken");
	hib_time_a: assert property (mode_out == TMPC_WAKING && $past(mode_out) == TMPC_HIBERNATE
		|-> ##[HIB_LO:HIB_HI] $rose(mode_out == TMPC_IDLE)) else $error("hibernate exit time");
	busy_pin_a: assert property (indicator_select_in && $rose(mode_out == TMPC_WARMUP) |=>
		out_of_idle_pin_out && !out_of_idle_pin_oe_n_out) else $error("out of idle flag");
	crc_pin_a: assert property (indicator_select_in && mode_out == TMPC_IDLE ##1
		indicator_select_in && mode_out == TMPC_IDLE |-> crc_ok_pin_out == $past(crc_valid_in))
		else $error("crc flag");
endmodule
bind tmpc_mode_ctrl tmpc_mode_ctrl_sva #(.OFF_TO_IDLE_CYC(OFF_TO_IDLE_CYC),
	.HIB_TO_IDLE_CYC(HIB_TO_IDLE_CYC), .IDLE_TO_RADIO_CYC(IDLE_TO_RADIO_CYC)) u_tmpc_mode_ctrl_sva (
	.clock_in(clock_in), .rst_n_in(rst_n_in), .radio_sequence_trigger_in(radio_sequence_trigger_in),
	.wake_request_n_in(wake_request_n_in), .indicator_select_in(indicator_select_in),
	.crc_valid_in(crc_valid_in), .mode_out(mode_out), .state_lost_out(state_lost_out),
	.receive_on_out(receive_on_out), .transmit_on_out(transmit_on_out),
	.out_of_idle_pin_out(out_of_idle_pin_out), .out_of_idle_pin_oe_n_out(out_of_idle_pin_oe_n_out),
	.crc_ok_pin_out(crc_ok_pin_out));
`default_nettype wire

// ---- tmpc_host_model.sv ----
// Host microcontroller model driving the trigger and wake pins.
`timescale 1ns/1ps
`default_nettype none
module tmpc_host_model (
	input wire logic clock_in,
	output logic trigger_out,
	output logic wake_n_out,
	output logic transmit_out
);
	initial begin
		trigger_out = 1'b0;
		wake_n_out = 1'b1;
		transmit_out = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// The sequence kind is settled a cycle before the trigger rises.
	task automatic raise(input logic tx);
		@(negedge clock_in) transmit_out = tx;
		@(negedge clock_in) trigger_out = 1'b1;
	endtask
	// Low long enough for the synchronisers to see a fresh edge next time.
	task automatic drop();
		trigger_out = 1'b0;
		repeat (6) @(negedge clock_in);
	endtask
	task automatic wake_pulse();
		@(negedge clock_in) wake_n_out = 1'b0;
		repeat (4) @(negedge clock_in);
		wake_n_out = 1'b1;
	endtask
endmodule
`default_nettype wire

// ---- transceiver_mode_pin_control_bench.sv ----
// Self-checking bench for the transceiver mode pin control.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
	$display("MISMATCH %0t bad value", $time); end end
module transceiver_mode_pin_control_bench;
	import tmpc_pkg::*;
	logic clock_in = 1'b0, rst_n_in = 1'b0, hib = 1'b0, doze = 1'b0, match = 1'b0, ind = 1'b0;
	logic crc = 1'b0, rx_on, tx_on, hclk, hclk_oe_n, ooi, ooi_oe_n, crcp, crcp_oe_n, lost;
	logic [2:0] sel = 3'h0;
	wire logic trig, wake_n, tx;
	tmpc_mode_e mode;
	int bad_count = 0, n_checks = 0, n;
	tmpc_host_model u_tmpc_host_model (.clock_in(clock_in), .trigger_out(trig),
		.wake_n_out(wake_n), .transmit_out(tx));
	tmpc_mode_ctrl #(.OFF_TO_IDLE_CYC(20), .HIB_TO_IDLE_CYC(16), .DOZE_TO_IDLE_CYC(8),
		.IDLE_TO_RADIO_CYC(10)) u_tmpc_mode_ctrl (.clock_in(clock_in), .rst_n_in(rst_n_in),
		.radio_sequence_trigger_in(trig), .wake_request_n_in(wake_n), .sequence_is_transmit_in(tx),
		.hibernate_request_in(hib), .doze_request_in(doze), .doze_timer_match_in(match),
		.doze_clock_enable_in(1'b0), .host_clock_select_in(sel), .indicator_select_in(ind),
		.crc_valid_in(crc), .mode_out(mode), .state_lost_out(lost), .receive_on_out(rx_on),
		.transmit_on_out(tx_on), .host_clock_out(hclk), .host_clock_oe_n_out(hclk_oe_n),
		.out_of_idle_pin_out(ooi), .out_of_idle_pin_oe_n_out(ooi_oe_n), .crc_ok_pin_out(crcp),
		.crc_ok_pin_oe_n_out(crcp_oe_n));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		forever #2.5 clock_in = ~clock_in;
	end
	task automatic conclude();
		if (bad_count == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic wait_mode(input tmpc_mode_e m);
		n = 0;
		while (mode !== m && n < 200) begin
			@(negedge clock_in);
			n++;
		end
	endtask
	task automatic t_reset();
		repeat (20) @(negedge clock_in);
		`CHK(mode, TMPC_OFF)
		`CHK({lost, hclk_oe_n, ooi_oe_n, crcp_oe_n}, 4'hf)
		rst_n_in = 1'b1;
		wait_mode(TMPC_IDLE);
		`CHK(n >= 18 && n <= 23, 1'b1)
		// The pin flops follow the mode one cycle later.
		@(negedge clock_in);
		`CHK(lost, 1'b0)
	endtask
	task automatic t_seq(input logic t, input int hold);
		u_tmpc_host_model.raise(t);
		repeat (hold) @(negedge clock_in);
		`CHK(mode, hold < 9 ? TMPC_WARMUP : t ? TMPC_TRANSMIT : TMPC_RECEIVE)
		`CHK({rx_on, tx_on, ooi_oe_n, ooi}, {hold > 9 && !t, hold > 9 && t, 2'h1})
		u_tmpc_host_model.drop();
		`CHK({mode, ooi}, {TMPC_IDLE, 1'b0})
	endtask
	// The doze timer exit skips the wake pin, so both exits get their own pass.
	task automatic t_sleep(input logic dz, input logic by_timer);
		doze = dz;
		hib = !dz;
		wait_mode(dz ? TMPC_DOZE : TMPC_HIBERNATE);
		hib = 1'b0;
		doze = 1'b0;
		repeat (3) @(negedge clock_in);
		`CHK(mode === TMPC_HIBERNATE && hclk !== 1'b0, 1'b0)
		match = by_timer;
		if (!by_timer) begin
			u_tmpc_host_model.wake_pulse();
		end
		wait_mode(TMPC_IDLE);
		// Cycles counted from the end of the wake pulse, or from the timer match.
		`CHK(n, by_timer ? 9 : dz ? 7 : 15)
		match = 1'b0;
		`CHK(mode, TMPC_IDLE)
	endtask
	task automatic t_crc();
		for (int i = 0; i < 2; i++) begin
			crc = i[0];
			repeat (3) @(negedge clock_in);
			`CHK({crcp_oe_n, crcp}, {1'b0, i[0]})
		end
	endtask
	task automatic t_clock();
		int div[8] = '{1, 2, 4, 8, 16, 256, 488, 976};
		realtime t0;
		for (int s = 0; s < 8; s++) begin
			@(negedge clock_in) sel = s[2:0];
			repeat (2) @(posedge hclk);
			t0 = $realtime;
			@(posedge hclk);
			`CHK(($realtime - t0 - div[s] * 62.5) ** 2 < 36.0 && !hclk_oe_n, 1'b1)
		end
	endtask
	initial begin
		repeat (90000) @(posedge clock_in);
		bad_count++;
		conclude();
	end
	initial begin
		t_reset();
		ind = 1'b1;
		t_seq(1'b0, 18);
		t_seq(1'b1, 18);
		t_seq(1'b0, 5);
		t_sleep(1'b0, 1'b0);
		t_sleep(1'b1, 1'b0);
		t_sleep(1'b1, 1'b1);
		t_crc();
		t_clock();
		conclude();
	end
endmodule
`default_nettype wire
